// ==== shared/seq_pkg.sv ====
// Behaviour
// RL1 - on first power-on with supply present, enter ACTIVE and power all rails
// RL2 - host disable or lock request passes 20 ms through FAULT first
// RL3 - any hard-reset fault while ACTIVE moves the device to FAULT
// RL4 - valid wake event in DISABLED or LOCKED enters ACTIVE with reset pulse
// RL5 - FAULT lasts the fault time, then ACTIVE with a reset pulse
// RL6 - after three hard-reset faults, FAULT leads to LOCKED instead
// RL7 - FAULT to LOCKED only with edge-mode wake or wake input low; after a host lock request the code enters LOCKED without this guard
// RL8 - a guarded transition needs all of its conditions true together
// RL9 - rail OV/short faults, pre/core/mon1 UV resets, boost UV and mon2 interrupt
// RL10 - watchdog error count increase raises an interrupt, no transition
// RL11 - watchdog error counter overflow resets the host, stays ACTIVE
// RL12 - first init timer expiry resets the host only
// RL13 - second init timer expiry sends the device to FAULT
// RL14 - band gap warning raises an interrupt only
// RL15 - band gap fault sends the device to FAULT
// RL16 - io supply OV/short fault, UV resets; OT warnings interrupt, faults FAULT
// RL17 - internal supply fault shuts down; ACTIVE with reset once cleared
// RL18 - init timer times out after 600 ms nominal, 550 to 650 ms
// RL19 - fault time 20 ms, or 1000 ms after thermal shutdown
// RL20 - every state transition completes within 100 us
package seq_pkg;
    // one-hot operating states
    typedef enum logic [4:0] {
        ST_OFF      = 5'b0_0001,
        ST_ACTIVE   = 5'b0_0010,
        ST_DISABLED = 5'b0_0100,
        ST_FAULT    = 5'b0_1000,
        ST_LOCKED   = 5'b1_0000
    } state_t;

    // rail index inside the four-bit rail event groups
    localparam int RAIL_PRE = 0;
    localparam int RAIL_CORE = 1;
    localparam int RAIL_BOOST = 2;
    localparam int RAIL_MON1 = 3;

    // timing
    localparam int CLK_KHZ = 200_000;
    localparam int T_INIT_MS = 600;
    localparam int T_INIT_MIN_MS = 550;
    localparam int T_INIT_MAX_MS = 650;
    localparam int T_FAULT_MS = 20;
    localparam int T_FAULT_TSD_MS = 1000;
    localparam int T_TRANS_US = 100;
    localparam int INIT_CYC = T_INIT_MS * CLK_KHZ;
    localparam int FAULT_CYC = T_FAULT_MS * CLK_KHZ;
    localparam int FAULT_TSD_CYC = T_FAULT_TSD_MS * CLK_KHZ;
    localparam int TRANS_CYC = T_TRANS_US * CLK_KHZ / 1000;
    localparam int RST_HOLD_CYC = 16;
    localparam int TIMER_W = 28;

    // hard-reset faults before lock-out, and reset values
    localparam logic [1:0] HARD_LIMIT = 2'h3;
    localparam logic [1:0] HCNT_RST = 2'h0;
    localparam logic [TIMER_W-1:0] TIMER_RST = 28'h000_0000;
endpackage

// ==== rtl/cycle_timer.sv ====
`timescale 1ns/1ps
module cycle_timer (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic load,
    input wire logic [seq_pkg::TIMER_W-1:0] load_val,
    input wire logic run,
    output logic expire,
    output logic busy
);
    import seq_pkg::*;

    logic [TIMER_W-1:0] cnt_q, cnt_d;
    logic expire_q, expire_d;

    // down counter, expiry flagged as a one-cycle pulse
    always_comb begin
        cnt_d = cnt_q;
        expire_d = 1'b0;
        if (load) begin
            cnt_d = load_val;
        end else if (run && cnt_q != TIMER_RST) begin
            cnt_d = cnt_q - 1'b1;
            expire_d = (cnt_q == {{(TIMER_W-1){1'b0}}, 1'b1});
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            cnt_q <= TIMER_RST;
            expire_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            expire_q <= expire_d;
        end
    end

    assign expire = expire_q;
    assign busy = (cnt_q != TIMER_RST);
endmodule

// ==== rtl/pmic_state_fault_sequencer.sv ====
`timescale 1ns/1ps
module pmic_state_fault_sequencer #(
    parameter int INIT_CYCLES = seq_pkg::INIT_CYC,
    parameter int FAULT_CYCLES = seq_pkg::FAULT_CYC,
    parameter int FAULT_TSD_CYCLES = seq_pkg::FAULT_TSD_CYC
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic supply_ok,
    input wire logic int_supply_fault,
    input wire logic [3:0] rail_ov,
    input wire logic [3:0] rail_uv,
    input wire logic [3:0] rail_stg,
    input wire logic [2:0] mon_two_evt,
    input wire logic io_ov,
    input wire logic io_uv,
    input wire logic io_stg,
    input wire logic wwd_err_inc,
    input wire logic wwd_err_ovf,
    input wire logic init_complete,
    input wire logic bg_warn,
    input wire logic bg_fault,
    input wire logic [2:0] ot_warn,
    input wire logic [2:0] ot_fault,
    input wire logic spi_req_disable,
    input wire logic spi_req_lock,
    input wire logic wake_input,
    input wire logic wake_edge_cfg,
    output logic mcu_reset_out_n,
    output logic rails_on,
    output logic irq_pulse,
    output logic [4:0] state_out,
    output logic [1:0] hard_count
);
    import seq_pkg::*;

    state_t state_q, state_d, target_q, target_d;
    logic [1:0] hcnt_q, hcnt_d;
    logic init_second_q, init_second_d;
    logic init_armed_q, init_armed_d;
    logic wake_prev_q;
    logic rst_n_q, rst_n_d;
    logic rails_q, irq_q;
    logic fault_load, rst_load, init_load;
    logic [TIMER_W-1:0] fault_val;
    logic fault_exp, init_exp, rst_busy;
    logic wake_rise, wake_event, hard_fault, soft_rst, irq_evt;
    logic lock_ok;

    // sized timer load values
    localparam logic [TIMER_W-1:0] INIT_LD = TIMER_W'(INIT_CYCLES);
    localparam logic [TIMER_W-1:0] FAULT_LD = TIMER_W'(FAULT_CYCLES);
    localparam logic [TIMER_W-1:0] TSD_LD = TIMER_W'(FAULT_TSD_CYCLES);
    localparam logic [TIMER_W-1:0] RST_LD = TIMER_W'(RST_HOLD_CYC);

    // valid enable: rising edge in edge mode, high level otherwise
    assign wake_rise = wake_input & ~wake_prev_q;
    assign wake_event = wake_edge_cfg ? wake_rise : wake_input;

    // event classification
    assign hard_fault = (|rail_ov) | (|rail_stg)       // see RL9
        | io_ov | io_stg | (|ot_fault)                 // see RL16
        | bg_fault                                     // see RL15
        | (init_exp & init_second_q);                  // see RL13
    assign soft_rst = rail_uv[RAIL_PRE] | rail_uv[RAIL_CORE]
        | rail_uv[RAIL_MON1] | io_uv                   // see RL9
        | wwd_err_ovf                                  // see RL11
        | (init_exp & ~init_second_q);                 // see RL12
    assign irq_evt = rail_uv[RAIL_BOOST] | (|mon_two_evt) // see RL9
        | wwd_err_inc                                  // see RL10
        | bg_warn                                      // see RL14
        | (|ot_warn);                                  // see RL16

    // lock-out needs count reached and wake guard, both at once
    assign lock_ok = (hcnt_q == HARD_LIMIT)            // see RL6
        && (wake_edge_cfg || !wake_input);             // see RL7 RL8

    // operating state next values, one cycle per transition
    always_comb begin
        state_d = state_q;
        target_d = target_q;
        hcnt_d = hcnt_q;
        fault_load = 1'b0;
        fault_val = FAULT_LD;
        rst_load = 1'b0;
        if (int_supply_fault) begin
            state_d = ST_OFF;                          // see RL17
        end else begin
            case (state_q)
                ST_OFF: begin
                    if (supply_ok) begin
                        state_d = ST_ACTIVE;           // see RL1 RL17
                        rst_load = 1'b1;
                    end
                end
                ST_ACTIVE: begin
                    if (hard_fault) begin
                        state_d = ST_FAULT;            // see RL3 RL20
                        target_d = ST_ACTIVE;
                        fault_load = 1'b1;
                        if (|ot_fault) begin
                            fault_val = TSD_LD;        // see RL19
                        end
                        if (hcnt_q != HARD_LIMIT) begin
                            hcnt_d = hcnt_q + 2'h1;    // see RL6
                        end
                    end else if (spi_req_disable) begin
                        state_d = ST_FAULT;            // see RL2
                        target_d = ST_DISABLED;
                        fault_load = 1'b1;
                    end else if (spi_req_lock) begin
                        state_d = ST_FAULT;            // see RL2
                        target_d = ST_LOCKED;
                        fault_load = 1'b1;
                    end else if (soft_rst) begin
                        rst_load = 1'b1;               // see RL11 RL12
                    end
                end
                ST_FAULT: begin
                    if (fault_exp) begin
                        if (target_q != ST_ACTIVE) begin
                            state_d = target_q;        // see RL2
                            hcnt_d = HCNT_RST;
                        end else if (lock_ok) begin
                            state_d = ST_LOCKED;       // see RL6 RL7
                            hcnt_d = HCNT_RST;
                        end else begin
                            state_d = ST_ACTIVE;       // see RL5
                            rst_load = 1'b1;
                        end
                    end
                end
                ST_DISABLED, ST_LOCKED: begin
                    if (wake_event) begin
                        state_d = ST_ACTIVE;           // see RL4
                        rst_load = 1'b1;
                    end
                end
                default: begin
                    state_d = ST_OFF;
                end
            endcase
        end
    end

    // host reset is low outside ACTIVE and while the pulse runs
    assign rst_n_d = (state_d == ST_ACTIVE) && !rst_load && !rst_busy;
    assign init_load = rst_n_d & ~rst_n_q;

    // init window: armed on reset release, stopped by configuration
    always_comb begin
        init_armed_d = init_armed_q;
        init_second_d = init_second_q;
        if (state_d != ST_ACTIVE) begin
            init_armed_d = 1'b0;
            if (state_d == ST_FAULT && state_q == ST_ACTIVE) begin
                init_second_d = 1'b0;
            end
        end else if (init_load) begin
            init_armed_d = 1'b1;
        end else if (init_complete) begin
            init_armed_d = 1'b0;
            init_second_d = 1'b0;
        end else if (init_exp) begin
            init_armed_d = 1'b0;
            init_second_d = 1'b1;                      // see RL12 RL13
        end
    end

    // state registers
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            state_q <= ST_OFF;
            target_q <= ST_ACTIVE;
            hcnt_q <= HCNT_RST;
            init_armed_q <= 1'b0;
            init_second_q <= 1'b0;
            wake_prev_q <= 1'b0;
            rst_n_q <= 1'b0;
            rails_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            state_q <= state_d;
            target_q <= target_d;
            hcnt_q <= hcnt_d;
            init_armed_q <= init_armed_d;
            init_second_q <= init_second_d;
            wake_prev_q <= wake_input;
            rst_n_q <= rst_n_d;
            rails_q <= (state_d == ST_ACTIVE);         // see RL1
            irq_q <= irq_evt && (state_q == ST_ACTIVE);
        end
    end

    // fault time, 20 ms or 1000 ms after thermal shutdown
    cycle_timer u_fault_tmr (
        .core_clk(core_clk),
        .nrst(nrst),
        .load(fault_load),
        .load_val(fault_val),
        .run(state_q == ST_FAULT),                     // see RL19
        .expire(fault_exp),
        .busy()
    );

    // initialization window timer
    cycle_timer u_init_tmr (
        .core_clk(core_clk),
        .nrst(nrst),
        .load(init_load),
        .load_val(INIT_LD),
        .run(init_armed_q && !init_complete),          // see RL18
        .expire(init_exp),
        .busy()
    );

    // host reset pulse width
    cycle_timer u_rst_tmr (
        .core_clk(core_clk),
        .nrst(nrst),
        .load(rst_load),
        .load_val(RST_LD),
        .run(1'b1),
        .expire(),
        .busy(rst_busy)
    );

    assign mcu_reset_out_n = rst_n_q;
    assign rails_on = rails_q;
    assign irq_pulse = irq_q;
    assign state_out = state_q;
    assign hard_count = hcnt_q;

    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    AST_POWER_UP: assert property ( // see RL1
        state_q == ST_OFF && supply_ok && !int_supply_fault
        |=> state_q == ST_ACTIVE && rails_on)
        else $error("no power-up into active");
    AST_REQ_VIA_FAULT: assert property ( // see RL2
        state_q == ST_ACTIVE && spi_req_lock && !hard_fault
        && !spi_req_disable && !int_supply_fault
        |=> state_q == ST_FAULT && target_q == ST_LOCKED)
        else $error("lock request skipped fault");
    AST_HARD_FAULT: assert property ( // see RL3
        state_q == ST_ACTIVE && hard_fault && !int_supply_fault
        |=> state_q == ST_FAULT ##1 !rails_on && !mcu_reset_out_n)
        else $error("hard fault not taken");
    AST_WAKE: assert property ( // see RL4
        (state_q == ST_DISABLED || state_q == ST_LOCKED) && wake_event
        && !int_supply_fault
        |=> state_q == ST_ACTIVE && !mcu_reset_out_n [*8])
        else $error("wake did not reset into active");
    AST_FAULT_EXIT: assert property ( // see RL5
        state_q == ST_FAULT && fault_exp && target_q == ST_ACTIVE
        && !lock_ok && !int_supply_fault
        |=> state_q == ST_ACTIVE && !mcu_reset_out_n)
        else $error("fault exit wrong");
    AST_LOCK: assert property ( // see RL6
        state_q == ST_FAULT && fault_exp && target_q == ST_ACTIVE
        && hcnt_q == HARD_LIMIT && !wake_input && !int_supply_fault
        |=> state_q == ST_LOCKED && hcnt_q == HCNT_RST)
        else $error("no lock after three faults");
    AST_LOCK_GUARD: assert property ( // see RL7
        state_q == ST_FAULT ##1 state_q == ST_LOCKED
        |-> $past(target_q) == ST_LOCKED
        || $past(wake_edge_cfg) || !$past(wake_input))
        else $error("lock taken with wake high in level mode");
    AST_IRQ_ONLY: assert property ( // see RL10
        state_q == ST_ACTIVE && wwd_err_inc && !hard_fault && !soft_rst
        && !spi_req_disable && !spi_req_lock && !int_supply_fault
        |=> irq_pulse && state_q == ST_ACTIVE)
        else $error("interrupt event misrouted");
    AST_WWD_OVF: assert property ( // see RL11
        state_q == ST_ACTIVE && wwd_err_ovf && !hard_fault
        && !spi_req_disable && !spi_req_lock && !int_supply_fault
        |=> state_q == ST_ACTIVE && !mcu_reset_out_n)
        else $error("overflow did not reset host");
    AST_SHUTDOWN: assert property ( // see RL17
        int_supply_fault |=> state_q == ST_OFF && !rails_on)
        else $error("internal supply fault ignored");

    COV_LOCKOUT: cover property (
        state_q == ST_FAULT ##1 state_q == ST_LOCKED);
    COV_DISABLE: cover property (
        state_q == ST_FAULT && target_q == ST_DISABLED ##1
        state_q == ST_DISABLED);
    COV_INIT_TWICE: cover property (init_exp && init_second_q);
endmodule

// ==== tb/host_mcu_model.sv ====
`timescale 1ns/1ps
// host side: serves the init window a few cycles after each reset
// release and issues state requests only while it runs
module host_mcu_model #(
    parameter int SERVE_DELAY = 6
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic mcu_reset_out_n,
    input wire logic serve_init,
    input wire logic cmd_disable,
    input wire logic cmd_lock,
    output logic init_complete,
    output logic spi_req_disable,
    output logic spi_req_lock
);
    logic [7:0] up_q;

    // count cycles since release, report init done once if serving
    always_ff @(posedge core_clk) begin
        if (!nrst || !mcu_reset_out_n) begin
            up_q <= 8'h00;
            init_complete <= 1'b0;
        end else begin
            up_q <= (up_q == 8'hff) ? up_q : up_q + 8'h01;
            init_complete <= serve_init && (up_q == 8'(SERVE_DELAY));
        end
    end

    // requests copy the commands one cycle later, from a running host only
    always_ff @(posedge core_clk) begin
        spi_req_disable <= nrst && mcu_reset_out_n && cmd_disable;
        spi_req_lock <= nrst && mcu_reset_out_n && cmd_lock;
    end
endmodule

// ==== tb/tb.sv ====
`timescale 1ns/1ps
module tb;
    import seq_pkg::*;
    localparam int INIT = 200;
    localparam int FLT = 50;
    localparam int THERMAL_SHUTDOWN = 120;
    logic core_clk, nrst, supply_ok, int_supply_fault;
    logic [27:0] ev;
    logic wake_input, wake_edge_cfg, serve_init, cmd_dis, cmd_lock;
    logic init_complete, spi_req_disable, spi_req_lock;
    logic mcu_reset_out_n, rails_on, irq_pulse;
    logic [4:0] state_out;
    logic [1:0] hard_count, hc;
    int bad_count = 0;
    int check_count = 0;
    int n;
    // one row per event bit: F fault, R host reset, I interrupt only
    string rows = "FFFFRRIRFFFFIIIFRFIRIFIIIFFF";

    pmic_state_fault_sequencer #(.INIT_CYCLES(INIT), .FAULT_CYCLES(FLT),
        .FAULT_TSD_CYCLES(THERMAL_SHUTDOWN)) dut (.core_clk(core_clk), .nrst(nrst),
        .supply_ok(supply_ok), .int_supply_fault(int_supply_fault),
        .rail_ov(ev[3:0]), .rail_uv(ev[7:4]), .rail_stg(ev[11:8]),
        .mon_two_evt(ev[14:12]), .io_ov(ev[15]), .io_uv(ev[16]),
        .io_stg(ev[17]), .wwd_err_inc(ev[18]), .wwd_err_ovf(ev[19]),
        .init_complete(init_complete), .bg_warn(ev[20]),
        .bg_fault(ev[21]), .ot_warn(ev[24:22]), .ot_fault(ev[27:25]),
        .spi_req_disable(spi_req_disable), .spi_req_lock(spi_req_lock),
        .wake_input(wake_input), .wake_edge_cfg(wake_edge_cfg),
        .mcu_reset_out_n(mcu_reset_out_n), .rails_on(rails_on),
        .irq_pulse(irq_pulse), .state_out(state_out),
        .hard_count(hard_count));

    host_mcu_model host (.core_clk(core_clk), .nrst(nrst),
        .mcu_reset_out_n(mcu_reset_out_n), .serve_init(serve_init),
        .cmd_disable(cmd_dis), .cmd_lock(cmd_lock),
        .init_complete(init_complete), .spi_req_disable(spi_req_disable),
        .spi_req_lock(spi_req_lock));

    // 200 MHz clock
    always #2.5 core_clk = ~core_clk;

    // compare tasks
    task automatic check_val(input string what, input logic [4:0] exp,
                             input logic [4:0] got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic check_bit(input string what, input logic exp,
                             input logic got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic check_span(input string what, input int lo, input int hi,
                              input int got);
        check_count++;
        if (got < lo || got > hi) begin
            bad_count++;
            $display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo,
                     hi, got);
        end
    endtask

    // bounded waits, sampled just after each edge
    task automatic wait_while(input logic [4:0] st, output int c);
        c = 0;
        while (state_out === st && c < 2000) begin
            @(posedge core_clk);
            #1;
            c++;
        end
    endtask

    task automatic wait_rst(input logic lvl, output int c);
        c = 0;
        while (mcu_reset_out_n !== lvl && c < 2000) begin
            @(posedge core_clk);
            #1;
            c++;
        end
    endtask

    // one-cycle pulse on one event bit, returns after the sampling edge
    task automatic fire(input int i);
        @(posedge core_clk);
        ev <= 28'h000_0001 << i;
        @(posedge core_clk);
        ev <= 28'h000_0000;
        #1;
    endtask

    // wake from a parked state, then wait for a served host
    task automatic ready;
        int c;
        if (state_out === ST_LOCKED || state_out === ST_DISABLED) begin
            @(posedge core_clk);
            wake_input <= 1'b1;
            wait_while(state_out, c);
            check_val("wake entry", ST_ACTIVE, state_out);
            @(posedge core_clk);
            wake_input <= ~wake_edge_cfg;
            #1;
            check_bit("wake reset", 1'b0, mcu_reset_out_n);
        end
        wait_rst(1'b1, c);
        repeat (12) @(posedge core_clk);
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // about 3000 cycles expected; give over ten times that
    initial begin
        #200_000;
        bad_count++;
        tally_and_finish();
    end

    initial begin
        core_clk = 0;
        nrst = 0;
        supply_ok = 1;
        int_supply_fault = 0;
        ev = '0;
        wake_input = 0;
        wake_edge_cfg = 1;
        serve_init = 1;
        cmd_dis = 0;
        cmd_lock = 0;
        hc = 2'h0;
        repeat (3) @(posedge core_clk);
        #1;
        check_val("state in reset", ST_OFF, state_out);
        check_bit("reset in reset", 1'b0, mcu_reset_out_n);
        @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        #1;
        check_val("power up", ST_ACTIVE, state_out);
        @(posedge core_clk);
        #1;
        check_bit("rails up", 1'b1, rails_on);
        ready();
        // event response table
        for (int i = 0; i < 28; i++) begin
            fire(i);
            if (rows[i] == "I") begin
                check_bit("irq", 1'b1, irq_pulse);
                check_val("irq state", ST_ACTIVE, state_out);
            end else if (rows[i] == "R") begin
                check_val("soft state", ST_ACTIVE, state_out);
                @(posedge core_clk);
                #1;
                check_bit("soft rst", 1'b0, mcu_reset_out_n);
            end else begin
                hc++;
                check_val("fault", ST_FAULT, state_out);
                check_val("count", {3'h0, hc}, {3'h0, hard_count});
                wait_while(ST_FAULT, n);
                check_span("fault time", (i > 24) ? THERMAL_SHUTDOWN : FLT,
                           ((i > 24) ? THERMAL_SHUTDOWN : FLT) + 4, n);
                check_val("fault exit", (hc == 2'h3) ? ST_LOCKED : ST_ACTIVE,
                          state_out);
                hc = (hc == 2'h3) ? 2'h0 : hc;
            end
            ready();
        end
        // lock request through the discharge time
        @(posedge core_clk);
        cmd_lock <= 1'b1;
        @(posedge core_clk);
        cmd_lock <= 1'b0;
        wait_while(ST_ACTIVE, n);
        check_val("lock via fault", ST_FAULT, state_out);
        wait_while(ST_FAULT, n);
        check_span("lock discharge", FLT, FLT + 4, n);
        check_val("locked", ST_LOCKED, state_out);
        check_val("count cleared", 5'h00, {3'h0, hard_count});
        ready();
        // disable request, then level-mode wake
        wake_edge_cfg <= 1'b0;
        @(posedge core_clk);
        cmd_dis <= 1'b1;
        @(posedge core_clk);
        cmd_dis <= 1'b0;
        wait_while(ST_ACTIVE, n);
        check_val("dis via fault", ST_FAULT, state_out);
        wait_while(ST_FAULT, n);
        check_val("disabled", ST_DISABLED, state_out);
        check_bit("rails off", 1'b0, rails_on);
        ready();
        // lock-out refused while level wake stays high
        repeat (4) begin
            if (hard_count !== 2'h3) begin
                fire(0);
                wait_while(ST_FAULT, n);
                check_val("no lockout", ST_ACTIVE, state_out);
                ready();
            end
        end
        fire(0);
        wait_while(ST_FAULT, n);
        check_val("guard fails", ST_ACTIVE, state_out);
        check_val("count held", 5'h03, {3'h0, hard_count});
        ready();
        wake_input <= 1'b0;
        wake_edge_cfg <= 1'b1;
        fire(0);
        wait_while(ST_FAULT, n);
        check_val("lockout", ST_LOCKED, state_out);
        ready();
        // init window never served by the host
        serve_init <= 1'b0;
        fire(4);
        wait_rst(1'b1, n);
        wait_rst(1'b0, n);
        check_span("init time", INIT * 550 / 600, INIT * 650 / 600,
                   n);
        check_val("first init", ST_ACTIVE, state_out);
        wait_rst(1'b1, n);
        wait_while(ST_ACTIVE, n);
        check_val("second init", ST_FAULT, state_out);
        serve_init <= 1'b1;
        wait_while(ST_FAULT, n);
        ready();
        // internal supply loss and recovery
        @(posedge core_clk);
        int_supply_fault <= 1'b1;
        wait_while(ST_ACTIVE, n);
        check_val("shutdown", ST_OFF, state_out);
        @(posedge core_clk);
        int_supply_fault <= 1'b0;
        #1;
        check_bit("rails down", 1'b0, rails_on);
        wait_while(ST_OFF, n);
        check_val("recover", ST_ACTIVE, state_out);
        check_bit("recover rst", 1'b0, mcu_reset_out_n);
        tally_and_finish();
    end
endmodule
